// *** rtl/sdram_link_if.sv ***
// pins between the memory controller and the memory device
interface sdram_link_if;
  logic link_clk;
  logic link_rst_n;
  logic [2:0] cmd;
  logic [1:0] bank;
  logic [3:0] col;
  logic chop_select_addr_bit;
  logic [7:0] dq;
  logic dqs;
  logic [7:0] rd_dq;
  logic rd_strobe;

  modport ctrl (
    output link_clk, link_rst_n, cmd, bank, col, chop_select_addr_bit, dq, dqs,
    input rd_dq, rd_strobe
  );
  modport dev (
    input link_clk, link_rst_n, cmd, bank, col, chop_select_addr_bit, dq, dqs,
    output rd_dq, rd_strobe
  );
endinterface

// *** rtl/sdram_wr_controller.sv ***
// memory controller end: apb registers, command buffer and link sequencer
// Notes on behaviour
// - field 00, or 01 with chop high: eight
// - field 01 with chop low: four-beat chop
// - field 10: always four-beat chop
// - recovery counts from rise after last beat
// - two-cycle preamble needs latency above lowest
// - checksum plus long preamble: spacing 6 becomes 7
// - checksum plus mask: use longer turnaround variants
// - general violation needs full link reset
// - strobe setup/hold fault corrupts only that address
// - strobe faults tolerated only without checksum, selection
// - bad strobe within six edges of latency
// - reads to open banks still served
// - same group follows at long column spacing
// - other group follows at short column spacing
// - after close-all, clean writes store correctly
// - first beat at additive plus cas latency
module sdram_wr_controller
  import sdram_wr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory link
  sdram_link_if.ctrl link
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ = 4'b0100,
    ST_RESET = 4'b1000
  } seq_state_type;

  seq_state_type state;
  logic [2:0] ph;
  logic [1:0] ctrl_burst;
  logic ctrl_crc;
  logic ctrl_pre2;
  logic ctrl_mask;
  logic [3:0] ctrl_cas;
  logic [3:0] ctrl_add;
  logic [63:0] wdata;
  logic [63:0] rdata;
  logic rd_done;
  logic refused;
  logic [73:0] buf_mem [0:1];
  logic buf_wp;
  logic buf_rp;
  logic [1:0] buf_cnt;
  logic [4:0] gap;
  logic [4:0] since_wr;
  logic [4:0] dwait;
  logic [3:0] left;
  logic [63:0] shreg;
  logic last_grp;
  logic [3:0] rcnt;
  logic [3:0] rlen;
  logic [4:0] rst_cnt;
  logic [8:0] rsync1;
  logic [8:0] rsync2;
  logic rstb_q;
  logic set_rdone;
  logic set_refused;
  cmd_type h_kind;

  // apb decode; a command write stalls while the buffer is full
  wire buf_full = (buf_cnt == 2'h2);
  wire buf_valid = (buf_cnt != 2'h0);
  wire is_cmd = (paddr == OFS_CMD);
  wire stall = pwrite & is_cmd & buf_full;
  wire apb_hit = psel & penable & pready;
  wire wr_en = apb_hit & pwrite;
  wire mapped = (paddr == OFS_CTRL) | is_cmd | (paddr == OFS_WDATA_LO)
                | (paddr == OFS_WDATA_HI) | (paddr == OFS_RDATA_LO)
                | (paddr == OFS_RDATA_HI) | (paddr == OFS_STATUS);
  wire [31:0] ctrl_word = {19'h0, ctrl_add, ctrl_cas, ctrl_mask, ctrl_pre2,
                           ctrl_crc, ctrl_burst};
  wire busy = buf_valid | (state != ST_IDLE);
  wire [31:0] status_word = {28'h0, buf_full, refused, rd_done, busy};
  wire [31:0] rd_mux = (paddr == OFS_CTRL) ? ctrl_word :
                       (paddr == OFS_WDATA_LO) ? wdata[31:0] :
                       (paddr == OFS_WDATA_HI) ? wdata[63:32] :
                       (paddr == OFS_RDATA_LO) ? rdata[31:0] :
                       (paddr == OFS_RDATA_HI) ? rdata[63:32] :
                       (paddr == OFS_STATUS) ? status_word : 32'h0;

  // head of the command buffer
  wire [73:0] head = buf_mem[buf_rp];
  assign h_kind = cmd_type'(head[2:0]);
  wire [1:0] h_bank = head[4:3];
  wire [3:0] h_col = head[8:5];
  wire h_chop = head[9];
  wire [63:0] h_data = head[73:10];
  wire [3:0] h_len = burst_beats(ctrl_burst, h_chop);
  wire [4:0] lat = {1'b0, ctrl_add} + {1'b0, ctrl_cas};
  wire same_grp = (h_bank[1] == last_grp);
  wire mode_bad = ctrl_pre2 & (ctrl_cas <= LOWEST_CAS);
  wire [4:0] crc_sp = (ctrl_pre2 && SPACING_CRC == 5'h6) ? SPACING_CRC_PRE2
                      : SPACING_CRC;
  wire [4:0] col_sp = same_grp ? LONG_COLUMN_SPACING
                      : SHORT_COLUMN_SPACING;
  wire [4:0] sp_need = ctrl_crc ? crc_sp : col_sp;
  wire [4:0] wtr_need = (ctrl_crc & ctrl_mask) ? (same_grp ? WTR_L_CRC_DM : WTR_S_CRC_DM)
                        : (same_grp ? WTR_L : WTR_S);
  wire read_ok = (since_wr >= wtr_need);
  wire issue_ok = (state == ST_IDLE) & (gap == 5'h0)
                  & ((h_kind != CMD_READ) | read_ok);
  wire pop = buf_valid & issue_ok & (ph == PH_FALL_UPD);
  wire push = wr_en & is_cmd;
  wire rise_upd = (ph == PH_RISE_UPD);
  wire beat_due = (dwait == 5'h1) | ((dwait == 5'h0) & (left != 4'h0));
  wire beat_now = (dwait == 5'h0) & (left != 4'h0);
  wire [2:0] next_ph = (ph == PH_LAST) ? 3'h0 : ph + 3'h1;
  wire rstb_edge = rsync2[8] ^ rstb_q;
  wire [7:0] mode_word = {lat, ctrl_crc, ctrl_burst};

  // apb answer: one wait-free access cycle, held off while stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~pready & ~stall;
      prdata <= rd_mux;
      pslverr <= psel & ~pready & ~stall & ~mapped;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_burst <= BURST_FIXED8;
      ctrl_crc <= 1'b0;
      ctrl_pre2 <= 1'b0;
      ctrl_mask <= 1'b0;
      ctrl_cas <= CTRL_RESET_CAS;
      ctrl_add <= 4'h0;
      wdata <= 64'h0;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        ctrl_burst <= pwdata[CTRL_BURST_POS +: 2];
        ctrl_crc <= pwdata[CTRL_CRC_POS];
        ctrl_pre2 <= pwdata[CTRL_PRE2_POS];
        ctrl_mask <= pwdata[CTRL_MASK_POS];
        ctrl_cas <= pwdata[CTRL_CAS_POS +: 4];
        ctrl_add <= pwdata[CTRL_ADD_POS +: 4];
      end
      if (paddr == OFS_WDATA_LO)
        wdata[31:0] <= pwdata;
      if (paddr == OFS_WDATA_HI)
        wdata[63:32] <= pwdata;
    end
  end

  // sticky status, write one to clear; a set in the same cycle wins
  wire clr_sts = wr_en & (paddr == OFS_STATUS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_done <= 1'b0;
      refused <= 1'b0;
    end else begin
      rd_done <= set_rdone | (rd_done & ~(clr_sts & pwdata[STS_RDONE_BIT]));
      refused <= set_refused | (refused & ~(clr_sts & pwdata[STS_REFUSED_BIT]));
    end
  end

  // two-entry command buffer; full stalls the apb command write
  always_ff @(posedge pclk) begin
    if (push)
      buf_mem[buf_wp] <= {wdata, pwdata[CMD_CHOP_POS], pwdata[CMD_COL_POS +: 4],
                          pwdata[CMD_BANK_POS +: 2], pwdata[CMD_KIND_POS +: 3]};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push)
        buf_wp <= ~buf_wp;
      if (pop)
        buf_rp <= ~buf_rp;
      if (push && !pop)
        buf_cnt <= buf_cnt + 2'h1;
      else if (pop && !push)
        buf_cnt <= buf_cnt - 2'h1;
    end
  end

  // link clock divider and read-return synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= PH_LAST; // so the first link high phase after reset is a full half cycle
      link.link_clk <= 1'b0;
      rsync1 <= 9'h0;
      rsync2 <= 9'h0;
      rstb_q <= 1'b0;
    end else begin
      ph <= next_ph;
      link.link_clk <= (next_ph < PH_HALF);
      rsync1 <= {link.rd_strobe, link.rd_dq};
      rsync2 <= rsync1;
      rstb_q <= rsync2[8];
    end
  end

  // command and data sequencer; command pins change half a link cycle from their sampling edge, data two pclk from its strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      gap <= 5'h0;
      since_wr <= 5'h1f;
      dwait <= 5'h0;
      left <= 4'h0;
      shreg <= 64'h0;
      last_grp <= 1'b0;
      rcnt <= 4'h0;
      rlen <= 4'h0;
      rst_cnt <= 5'h0;
      rdata <= 64'h0;
      set_rdone <= 1'b0;
      set_refused <= 1'b0;
      link.link_rst_n <= 1'b1;
      link.cmd <= CMD_NOP;
      link.bank <= 2'h0;
      link.col <= 4'h0;
      link.chop_select_addr_bit <= 1'b0;
      link.dq <= 8'h0;
      link.dqs <= 1'b0;
    end else begin
      set_rdone <= 1'b0;
      set_refused <= 1'b0;
      if (rise_upd) begin
        if (gap != 5'h0)
          gap <= gap - 5'h1;
        if (since_wr != 5'h1f)
          since_wr <= since_wr + 5'h1;
        if (dwait != 5'h0)
          dwait <= dwait - 5'h1;
      end
      if (ph == PH_FALL_UPD)
        link.cmd <= CMD_NOP;
      unique case (state)
        ST_IDLE: begin
          if (pop) begin
            link.bank <= h_bank;
            link.col <= h_col;
            link.chop_select_addr_bit <= h_chop;
            gap <= SHORT_COLUMN_SPACING;
            unique case (h_kind)
              CMD_MODE: begin
                if (mode_bad) begin
                  set_refused <= 1'b1;
                end else begin
                  link.cmd <= CMD_MODE;
                  link.dq <= mode_word;
                end
              end
              CMD_WRITE, CMD_WRITE_AP: begin
                link.cmd <= h_kind;
                state <= ST_WRITE;
                dwait <= lat + 5'h1;
                left <= h_len;
                shreg <= h_data;
                gap <= sp_need;
                last_grp <= h_bank[1];
              end
              CMD_READ: begin
                link.cmd <= CMD_READ;
                state <= ST_READ;
                rcnt <= 4'h0;
                rlen <= h_len;
              end
              CMD_RESET: begin
                link.link_rst_n <= 1'b0;
                state <= ST_RESET;
                rst_cnt <= RESET_CLOCKS;
              end
              CMD_ACT, CMD_PRE_ALL: link.cmd <= h_kind;
              CMD_NOP: link.cmd <= CMD_NOP;
            endcase
          end
        end
        ST_WRITE: begin
          // data leads its strobe toggle by two pclk so the device sees it settled
          if ((ph == PH_DQ_RISE && beat_due) || (ph == PH_DQ_FALL && beat_now)) begin
            link.dq <= shreg[7:0];
            shreg <= {8'h0, shreg[63:8]};
          end
          if ((rise_upd && beat_due) || (ph == PH_FALL_UPD && beat_now)) begin
            link.dqs <= ~link.dqs;
            left <= left - 4'h1;
            if (left == 4'h1) begin
              state <= ST_IDLE;
              since_wr <= 5'h0;
            end
          end
        end
        ST_READ: begin
          if (rstb_edge) begin
            rdata[{rcnt[2:0], 3'h0} +: 8] <= rsync2[7:0];
            rcnt <= rcnt + 4'h1;
            if (rcnt + 4'h1 == rlen) begin
              state <= ST_IDLE;
              set_rdone <= 1'b1;
            end
          end
        end
        ST_RESET: begin
          if (rise_upd) begin
            rst_cnt <= rst_cnt - 5'h1;
            if (rst_cnt == 5'h1) begin
              link.link_rst_n <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

// *** rtl/sdram_wr_device.sv ***
// memory device end: burst capture, violation tolerance and read-out
module sdram_wr_device
  import sdram_wr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // memory link
  sdram_link_if.dev link,
  // device status
  output logic [1:0] mode_burst,
  output logic mode_checksum,
  output logic [4:0] total_write_latency,
  output logic fault,
  output logic [3:0] banks_open,
  output logic [3:0] banks_offended
);
  logic [20:0] sync1;
  logic [20:0] sync2;
  logic clk_q;
  logic dqs_q;
  logic [1:0] slot_busy;
  logic [1:0] slot_ap;
  logic [4:0] slot_cnt [0:1];
  logic [5:0] slot_addr [0:1];
  logic [3:0] slot_len [0:1];
  logic head;
  logic tail;
  logic [2:0] beat;
  logic [7:0] mem [0:MEM_DEPTH-1];
  logic rd_busy;
  logic [2:0] rd_tmr;
  logic [5:0] rd_addr;
  logic [2:0] rd_idx;
  logic [3:0] rd_left;
  cmd_type s_kind;

  // every link pin crosses two flops; the first is read by the second only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      clk_q <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      sync1 <= {link.link_clk, link.link_rst_n, link.cmd, link.bank, link.col,
                link.chop_select_addr_bit, link.dq, link.dqs};
      sync2 <= sync1;
      clk_q <= sync2[20];
      dqs_q <= sync2[0];
    end
  end

  // unpacked synchronised pins and edges
  wire s_rst_n = sync2[19];
  wire [1:0] s_bank = sync2[15:14];
  wire [3:0] s_col = sync2[13:10];
  wire s_chop = sync2[9];
  wire [7:0] s_dq = sync2[8:1];
  wire rise = sync2[20] & ~clk_q;
  wire strobe_edge = sync2[0] ^ dqs_q;
  assign s_kind = cmd_type'(sync2[18:16]);
  wire take = rise & s_rst_n;
  wire is_write = take & (s_kind == CMD_WRITE || s_kind == CMD_WRITE_AP);

  // per-write length, window and timeout of the head slot
  wire [3:0] new_len = burst_beats(mode_burst, s_chop);
  wire [4:0] h_cnt = slot_cnt[head];
  wire [3:0] h_len = slot_len[head];
  wire [1:0] h_bank = slot_addr[head][5:4];
  wire [5:0] deadline = {1'b0, total_write_latency} + {3'b0, h_len[3:1]}
                        + {1'b0, TOL_CLOCKS};
  wire in_window = ({1'b0, h_cnt} + {1'b0, TOL_CLOCKS})
                   >= {1'b0, total_write_latency};
  wire beat_ok = slot_busy[head] & strobe_edge & in_window & s_rst_n;
  wire early = slot_busy[head] & strobe_edge & ~in_window;
  wire late = slot_busy[head] & rise & ({1'b0, h_cnt} >= deadline);
  wire last_beat = beat_ok & (({1'b0, beat} + 4'h1) == h_len);
  wire offend = (early | late) & s_rst_n;
  wire free_head = (last_beat | late) & s_rst_n;
  wire load = is_write & ~slot_busy[tail];
  wire strict = mode_checksum | (mode_burst == BURST_OTF);
  wire rd_start = take & (s_kind == CMD_READ) & ~rd_busy;

  // one beat per strobe edge, both polarities; a bad strobe only corrupts this address
  always_ff @(posedge pclk) begin
    if (beat_ok)
      mem[{slot_addr[head], beat}] <= s_dq;
  end

  // two write slots, so a second write may follow at column spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_busy <= 2'h0;
      slot_ap <= 2'h0;
      head <= 1'b0;
      tail <= 1'b0;
      beat <= 3'h0;
      for (int i = 0; i < 2; i++) begin
        slot_cnt[i] <= 5'h0;
        slot_addr[i] <= 6'h0;
        slot_len[i] <= 4'h0;
      end
    end else if (!s_rst_n) begin
      slot_busy <= 2'h0;
      head <= 1'b0;
      tail <= 1'b0;
      beat <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rise && slot_busy[i] && slot_cnt[i] != 5'h1f)
          slot_cnt[i] <= slot_cnt[i] + 5'h1;
      end
      if (beat_ok)
        beat <= beat + 3'h1;
      if (free_head) begin
        slot_busy[head] <= 1'b0;
        head <= ~head;
        beat <= 3'h0;
      end
      if (load) begin
        slot_busy[tail] <= 1'b1;
        slot_ap[tail] <= (s_kind == CMD_WRITE_AP);
        slot_cnt[tail] <= 5'h0;
        slot_addr[tail] <= {s_bank, s_col};
        slot_len[tail] <= new_len;
        tail <= ~tail;
      end
    end
  end

  // mode, bank state and fault; a link reset restores these and the write slots, but not the read-out or the array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_burst <= BURST_FIXED8;
      mode_checksum <= 1'b0;
      total_write_latency <= RESET_LATENCY;
      fault <= 1'b0;
      banks_open <= 4'h0;
      banks_offended <= 4'h0;
    end else if (!s_rst_n) begin
      mode_burst <= BURST_FIXED8;
      mode_checksum <= 1'b0;
      total_write_latency <= RESET_LATENCY;
      fault <= 1'b0;
      banks_open <= 4'h0;
      banks_offended <= 4'h0;
    end else begin
      if (take && s_kind == CMD_MODE) begin
        mode_burst <= s_dq[MODE_BURST_POS +: 2];
        mode_checksum <= s_dq[MODE_CRC_POS];
        total_write_latency <= s_dq[MODE_LAT_POS +: 5];
      end
      if (take && s_kind == CMD_ACT)
        banks_open[s_bank] <= 1'b1;
      if (free_head && slot_ap[head])
        banks_open[h_bank] <= 1'b0;
      if (take && s_kind == CMD_PRE_ALL) begin
        banks_open <= 4'h0;
        banks_offended <= 4'h0;
      end
      // an offence in the same cycle as close-all still marks its bank
      if (offend)
        banks_offended[h_bank] <= 1'b1;
      // tolerance holds only with checksum and per-command select both off
      if (offend && strict)
        fault <= 1'b1;
    end
  end

  // read-out: one beat per link period, strobe toggles mid-beat; offended banks still read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_busy <= 1'b0;
      rd_tmr <= 3'h0;
      rd_addr <= 6'h0;
      rd_idx <= 3'h0;
      rd_left <= 4'h0;
      link.rd_dq <= 8'h0;
      link.rd_strobe <= 1'b0;
    end else if (rd_start) begin
      rd_busy <= 1'b1;
      rd_tmr <= 3'h0;
      rd_addr <= {s_bank, s_col};
      rd_idx <= 3'h0;
      rd_left <= new_len;
    end else if (rd_busy) begin
      rd_tmr <= rd_tmr + 3'h1;
      if (rd_tmr == 3'h0)
        link.rd_dq <= mem[{rd_addr, rd_idx}];
      if (rd_tmr == PH_HALF) begin
        link.rd_strobe <= ~link.rd_strobe;
        rd_idx <= rd_idx + 3'h1;
        rd_left <= rd_left - 4'h1;
        if (rd_left == 4'h1)
          rd_busy <= 1'b0;
      end
    end
  end
endmodule

// *** rtl/sdram_wr_pkg.sv ***
// shared constants, types and burst decoding for the write-path link
package sdram_wr_pkg;
  // link clock is pclk divided down; one link cycle is LINK_DIV pclk phases
  localparam int PCLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_DIV = LINK_PERIOD_NS / PCLK_PERIOD_NS;
  localparam logic [2:0] PH_LAST = 3'(LINK_DIV - 1);
  localparam logic [2:0] PH_HALF = 3'(LINK_DIV / 2);
  // pclk phases at which the controller updates its pins
  localparam logic [2:0] PH_FALL_UPD = PH_HALF - 3'h1;
  localparam logic [2:0] PH_RISE_UPD = PH_LAST;
  localparam logic [2:0] PH_DQ_RISE = PH_LAST - 3'h2;
  localparam logic [2:0] PH_DQ_FALL = PH_HALF - 3'h3;

  // link commands
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MODE = 3'h1,
    CMD_ACT = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_WRITE_AP = 3'h4,
    CMD_READ = 3'h5,
    CMD_PRE_ALL = 3'h6,
    CMD_RESET = 3'h7
  } cmd_type;

  // burst-length field of mode_reg_zero
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;
  localparam logic [3:0] EIGHT_BEAT_BURST = 4'h8;
  localparam logic [3:0] FOUR_BEAT_CHOP = 4'h4;

  // timing in link clocks
  localparam logic [4:0] TOL_CLOCKS = 5'h3;
  localparam logic [3:0] LOWEST_CAS = 4'h9;
  localparam logic [4:0] SHORT_COLUMN_SPACING = 5'h4;
  localparam logic [4:0] LONG_COLUMN_SPACING = 5'h6;
  localparam logic [4:0] SPACING_CRC = 5'h6;
  localparam logic [4:0] SPACING_CRC_PRE2 = 5'h7;
  localparam logic [4:0] WTR_S = 5'h3;
  localparam logic [4:0] WTR_L = 5'h6;
  localparam logic [4:0] WTR_S_CRC_DM = 5'h5;
  localparam logic [4:0] WTR_L_CRC_DM = 5'h8;
  localparam logic [4:0] RESET_CLOCKS = 5'h4;

  // controller apb map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_WDATA_LO = 8'h08;
  localparam logic [7:0] OFS_WDATA_HI = 8'h0c;
  localparam logic [7:0] OFS_RDATA_LO = 8'h10;
  localparam logic [7:0] OFS_RDATA_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ctrl fields
  localparam int CTRL_BURST_POS = 0;
  localparam int CTRL_CRC_POS = 2;
  localparam int CTRL_PRE2_POS = 3;
  localparam int CTRL_MASK_POS = 4;
  localparam int CTRL_CAS_POS = 5;
  localparam int CTRL_ADD_POS = 9;
  localparam logic [3:0] CTRL_RESET_CAS = 4'ha;
  // cmd fields
  localparam int CMD_KIND_POS = 0;
  localparam int CMD_BANK_POS = 3;
  localparam int CMD_COL_POS = 5;
  localparam int CMD_CHOP_POS = 9;
  // status bits
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_RDONE_BIT = 1;
  localparam int STS_REFUSED_BIT = 2;
  localparam int STS_FULL_BIT = 3;

  // mode word carried on dq with CMD_MODE
  localparam int MODE_BURST_POS = 0;
  localparam int MODE_CRC_POS = 2;
  localparam int MODE_LAT_POS = 3;
  localparam logic [4:0] RESET_LATENCY = {1'b0, CTRL_RESET_CAS};
  localparam int MEM_DEPTH = 512;

  // beats per write from the burst field and the chop bit
  function automatic logic [3:0] burst_beats(input logic [1:0] field, input logic chop);
    if (field == BURST_FIXED4)
      return FOUR_BEAT_CHOP;
    if (field == BURST_OTF && !chop)
      return FOUR_BEAT_CHOP;
    return EIGHT_BEAT_BURST;
  endfunction
endpackage

// *** tb/sdram_wr_assertions.sv ***
// link-side concurrent checks for the write-path link
module sdram_wr_assertions
  import sdram_wr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link pins
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic [2:0] cmd,
  input wire logic [7:0] dq,
  input wire logic dqs,
  input wire logic [7:0] rd_dq,
  input wire logic rd_strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // link clock halves are four pclk each
  sequence s_high; link_clk [*4] ##1 !link_clk; endsequence
  sequence s_low; !link_clk [*4] ##1 link_clk; endsequence
  property p_clk_high; $rose(link_clk) |-> s_high; endproperty
  property p_clk_low; $fell(link_clk) |-> s_low; endproperty
  // commands move only at the falling link edge, so the device sees them settled
  property p_cmd_fall; $changed(cmd) |-> $fell(link_clk); endproperty
  property p_cmd_stand; ($changed(cmd) && cmd != CMD_NOP) |=> $stable(cmd) [*7]; endproperty
  // strobe toggles ride the link edges, at least half a link cycle apart
  property p_dqs_edge; $changed(dqs) |-> $changed(link_clk); endproperty
  property p_dqs_gap; $changed(dqs) |=> $stable(dqs) [*3]; endproperty
  property p_dq_hold; $changed(dqs) |-> $stable(dq); endproperty
  property p_rd_gap; $changed(rd_strobe) |=> $stable(rd_strobe) [*7]; endproperty
  property p_rd_hold; $changed(rd_strobe) |-> $stable(rd_dq); endproperty
  property p_lrst; $fell(link_rst_n) |-> !link_rst_n [*8]; endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high time");
  a_clk_low: assert property (p_clk_low) else $error("link clock low time");
  a_cmd_fall: assert property (p_cmd_fall) else $error("command off edge");
  a_cmd_stand: assert property (p_cmd_stand) else $error("command too short");
  a_dqs_edge: assert property (p_dqs_edge) else $error("strobe off edge");
  a_dqs_gap: assert property (p_dqs_gap) else $error("strobe too fast");
  a_dq_hold: assert property (p_dq_hold) else $error("data moved at strobe");
  a_rd_gap: assert property (p_rd_gap) else $error("read strobe too fast");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_lrst: assert property (p_lrst) else $error("link reset too short");
endmodule

// *** tb/testbench.sv ***
// self-checking bench: controller and device joined over the link
module testbench
  import sdram_wr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, slv, mode_checksum, fault;
  logic [1:0] mode_burst;
  logic [4:0] total_write_latency;
  logic [3:0] banks_open, banks_offended;
  int err_count = 0, comparisons = 0, cycles = 0;
  // burst cases: field, chop bit, whether all eight beats land
  logic [1:0] fld [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
  logic chp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic full [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  sdram_link_if link ();
  sdram_wr_controller u_sdram_wr_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  sdram_wr_device u_sdram_wr_device (.pclk(pclk), .presetn(presetn), .link(link),
    .mode_burst(mode_burst), .mode_checksum(mode_checksum),
    .total_write_latency(total_write_latency), .fault(fault), .banks_open(banks_open),
    .banks_offended(banks_offended));
  sdram_wr_assertions u_sdram_wr_assertions (.pclk(pclk), .presetn(presetn),
    .link_clk(link.link_clk), .link_rst_n(link.link_rst_n), .cmd(link.cmd), .dq(link.dq),
    .dqs(link.dqs), .rd_dq(link.rd_dq), .rd_strobe(link.rd_strobe));
  always #5 pclk = ~pclk;
  // hang guard: far above the few thousand cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // one apb transfer; an idle cycle after it keeps psel from toggling in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      err_count++;
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    rd = {32{~v}};
    while (rd[b] !== v && n < 200) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    if (rd[b] !== v)
      err_count++;
  endtask
  task automatic cmd(input cmd_type k, input logic [1:0] b, input logic [3:0] c, input logic h);
    apb(1'b1, OFS_CMD, {22'h0, h, c, b, k});
    wait_bit(STS_BUSY_BIT, 1'b0);
    // busy drops at issue, or when a write, read or reset ends; the device acts half a link cycle and two sync flops later
    repeat (2 * LINK_DIV) @(posedge pclk);
  endtask
  task automatic wr(input logic [3:0] c, input logic h, input logic [31:0] lo, hi);
    apb(1'b1, OFS_WDATA_LO, lo);
    apb(1'b1, OFS_WDATA_HI, hi);
    cmd(CMD_WRITE, 2'h1, c, h);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl", rd, 32'({CTRL_RESET_CAS, 5'h0}));
    check("latency", 32'(total_write_latency), 32'(RESET_LATENCY));
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped", 32'(slv), 32'h1);
    cmd(CMD_ACT, 2'h1, 4'h0, 1'b0);
    check("open", 32'(banks_open), 32'h2);
    // prefill eight beats, then overwrite in each mode: a chop leaves the top half
    for (int i = 0; i < 4; i++) wr(4'(i), 1'b1, 32'ha0a1a2a3, 32'ha4a5a6a7);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_CTRL, 32'({CTRL_RESET_CAS, 3'h0, fld[i]}));
      cmd(CMD_MODE, 2'h0, 4'h0, 1'b0);
      check("burst", 32'(mode_burst), 32'(fld[i]));
      wr(4'(i), chp[i], {28'hb0b1b2b, 4'(i)}, 32'hc4c5c6c7);
    end
    apb(1'b1, OFS_CTRL, 32'({CTRL_RESET_CAS, 5'h0}));
    cmd(CMD_MODE, 2'h0, 4'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_READ, 2'h1, 4'(i), 1'b1);
      wait_bit(STS_RDONE_BIT, 1'b1);
      apb(1'b0, OFS_RDATA_LO, 32'h0);
      check("lo", rd, {28'hb0b1b2b, 4'(i)});
      apb(1'b0, OFS_RDATA_HI, 32'h0);
      check("hi", rd, full[i] ? 32'hc4c5c6c7 : 32'ha4a5a6a7);
      apb(1'b1, OFS_STATUS, 32'h2);
    end
    check("flags", 32'({fault, banks_offended, mode_checksum}), 32'h0);
    // long preamble with the lowest latency must be refused
    apb(1'b1, OFS_CTRL, 32'({4'h9, 5'h08}));
    cmd(CMD_MODE, 2'h0, 4'h0, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("refused", 32'(rd[STS_REFUSED_BIT]), 32'h1);
    cmd(CMD_PRE_ALL, 2'h0, 4'h0, 1'b0);
    check("closed", 32'(banks_open), 32'h0);
    cmd(CMD_ACT, 2'h2, 4'h0, 1'b0);
    check("open2", 32'(banks_open), 32'h4);
    cmd(CMD_RESET, 2'h0, 4'h0, 1'b0);
    check("reset", 32'(banks_open), 32'h0);
    stop_test();
  end
endmodule
